// File: rtl/imac_pkg.sv
// Shared constants for the I2C master acknowledge and command control block.
// What this block does
// - After a received byte the master drives ACK when the response bit 18 is 0 and NACK when it is 1.
// - The acknowledge action runs on a command write, and also on a data read when smart mode bit 8 is set.
// - The two-bit command field is a write-only strobe that launches a bus operation and always reads zero.
// - The acknowledge action only happens in master read mode; in write mode a command gives only repeated start or stop.
// - When one write sets both the response bit and a command, the response is updated before the command runs.
// - A command is taken only while the slave-on-bus or the master-on-bus flag is 1.
// - The response bit is writable while enabled and acts without write synchronisation, unlike commands.
package imac_pkg;
    // Register offsets (byte addresses).
    localparam logic [7:0] OFF_ENABLE = 8'h00;
    localparam logic [7:0] OFF_CTRL = 8'h04;
    localparam logic [7:0] OFF_MASK = 8'h10;
    localparam logic [7:0] OFF_STATUS = 8'h14;
    localparam logic [7:0] OFF_DATA = 8'h18;
    localparam logic [7:0] OFF_SYNCBUSY = 8'h1c;
    // Field positions.
    localparam int ENABLE_BIT = 0;
    localparam int SMART_BIT = 8;
    localparam int CMD_LO = 16;
    localparam int CMD_HI = 17;
    localparam int ACK_BIT = 18;
    // Reset values.
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [2:0] STATUS_RST = 3'h0;
    // Sticky status bits.
    localparam int ST_W = 3;
    localparam int ST_DONE = 0;
    localparam int ST_DROP = 1;
    localparam int ST_SMART = 2;
    // Command codes.
    localparam logic [1:0] CMD_NONE = 2'h0;
    localparam logic [1:0] CMD_RSTART = 2'h1;
    localparam logic [1:0] CMD_READ = 2'h2;
    localparam logic [1:0] CMD_STOP = 2'h3;
    // Write synchroniser depth in clock cycles.
    localparam int SYNC_STAGES = 2;
endpackage

// File: rtl/imac_cmd_if.sv
// Command hand-off between the register side and the bus sequencer.
`timescale 1ns/1ps
`default_nettype none
interface imac_cmd_if;
    logic cmd_valid;
    logic [1:0] cmd_code;
    logic cmd_read;
    logic ack_nack;
    logic busy;
    logic done;
    modport ctl (output cmd_valid, output cmd_code, output cmd_read,
                 output ack_nack, input busy, input done);
    modport seq (input cmd_valid, input cmd_code, input cmd_read,
                 input ack_nack, output busy, output done);
endinterface // imac_cmd_if
`default_nettype wire

// File: rtl/imac_wsync.sv
// Write synchroniser: delays a command word by a fixed number of cycles.
`timescale 1ns/1ps
`default_nettype none
module imac_wsync #(
    parameter int STAGES = imac_pkg::SYNC_STAGES,
    parameter int W = 3
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Request in.
    input wire logic req_i,
    input wire logic [W-1:0] data_i,
    // Request out after the delay.
    output logic req_o,
    output logic [W-1:0] data_o,
    output logic busy_o
);
    logic [STAGES-1:0] vld_r, vld_nxt;
    logic [W-1:0] data_r, data_nxt;

    if (STAGES < 1) begin : g_chk
        $error("imac_wsync needs at least one stage");
    end

    // Shift the valid bit along; the payload is held, since only one
    // word can be in flight while busy blocks new requests upstream.
    always_comb begin
        // The size cast keeps the low bits, so the oldest stage falls off.
        vld_nxt = STAGES'({vld_r, req_i});
        data_nxt = req_i ? data_i : data_r;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            vld_r <= '0;
            data_r <= '0;
        end else begin
            vld_r <= vld_nxt;
            data_r <= data_nxt;
        end
    end

    assign req_o = vld_r[STAGES-1];
    assign data_o = data_r;
    assign busy_o = |vld_r;
endmodule // imac_wsync
`default_nettype wire

// File: rtl/imac_seq.sv
// Bus action sequencer: acknowledge action first, then the bus condition.
`timescale 1ns/1ps
`default_nettype none
module imac_seq (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Command hand-off.
    imac_cmd_if.seq cif,
    // Toward the bus engine.
    output logic ack_strobe_o,
    output logic ack_nack_o,
    output logic cond_strobe_o,
    output logic [1:0] cond_op_o
);
    typedef enum logic {SEQ_IDLE, SEQ_COND} imac_seq_state_t;
    imac_seq_state_t state_r, state_nxt;
    logic ack_stb_r, ack_stb_nxt, nack_r, nack_nxt;
    logic cond_stb_r, cond_stb_nxt, done_r, done_nxt;
    logic [1:0] op_r, op_nxt;

    // Next state and strobes. The response bit is sampled live when the
    // command leaves the synchroniser, so a same-write update is seen.
    always_comb begin
        state_nxt = state_r;
        ack_stb_nxt = 1'b0;
        nack_nxt = nack_r;
        cond_stb_nxt = 1'b0;
        op_nxt = op_r;
        done_nxt = 1'b0;
        unique case (state_r)
            SEQ_IDLE: begin
                if (cif.cmd_valid) begin
                    op_nxt = cif.cmd_code;
                    if (cif.cmd_read) begin
                        ack_stb_nxt = 1'b1;
                        nack_nxt = cif.ack_nack;
                        state_nxt = SEQ_COND;
                    end else begin
                        // Write mode: only repeated start or stop reach the bus.
                        cond_stb_nxt = (cif.cmd_code != imac_pkg::CMD_READ);
                        done_nxt = 1'b1;
                    end
                end
            end
            SEQ_COND: begin
                cond_stb_nxt = 1'b1;
                done_nxt = 1'b1;
                state_nxt = SEQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            state_r <= SEQ_IDLE;
            ack_stb_r <= 1'b0;
            nack_r <= 1'b0;
            cond_stb_r <= 1'b0;
            op_r <= imac_pkg::CMD_NONE;
            done_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            ack_stb_r <= ack_stb_nxt;
            nack_r <= nack_nxt;
            cond_stb_r <= cond_stb_nxt;
            op_r <= op_nxt;
            done_r <= done_nxt;
        end
    end

    assign ack_strobe_o = ack_stb_r;
    assign ack_nack_o = nack_r;
    assign cond_strobe_o = cond_stb_r;
    assign cond_op_o = op_r;
    assign cif.busy = (state_r != SEQ_IDLE);
    assign cif.done = done_r;

    // The condition always follows the acknowledge by exactly one cycle.
    a_ack_then_cond: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        ack_strobe_o |=> cond_strobe_o)
        else $error("bus condition did not follow the acknowledge");
endmodule // imac_seq
`default_nettype wire

// File: rtl/imac_top.sv
// Top of the I2C master acknowledge and command control block.
`timescale 1ns/1ps
`default_nettype none
module imac_top #(
    parameter int SYNC_STAGES = imac_pkg::SYNC_STAGES,
    parameter int RX_W = 8
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Register port.
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    // Bus engine state, same clock.
    input wire logic master_on_bus_flag_i,
    input wire logic slave_on_bus_flag_i,
    input wire logic read_mode_i,
    input wire logic [RX_W-1:0] rx_data_i,
    // Bus engine actions.
    output logic ack_strobe_o,
    output logic ack_nack_o,
    output logic cond_strobe_o,
    output logic [1:0] cond_op_o,
    // Block state.
    output logic enable_o,
    output logic irq_o
);
    localparam int SYNC_D = SYNC_STAGES + 1;

    if (RX_W < 1 || RX_W > 32 || SYNC_STAGES < 1) begin : g_chk
        $error("imac_top parameters out of range");
    end

    imac_cmd_if cif ();

    logic enable_r, enable_nxt;
    logic ack_r, ack_nxt;
    logic smart_r, smart_nxt;
    logic [imac_pkg::ST_W-1:0] status_r, status_nxt, mask_r, mask_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic wr_ctrl, rd_data, owned, path_busy;
    logic [1:0] wr_cmd;
    logic cmd_take, cmd_drop, smart_take, sync_req, sync_busy;
    logic [2:0] sync_in, sync_out;
    logic [imac_pkg::ST_W-1:0] st_set;

    ////////////////////////////////////////////////////////////////////////
    // Command acceptance.

    // A command needs bus ownership and an idle path; otherwise it is
    // dropped at write time so it can never surface later on the bus.
    always_comb begin
        wr_ctrl = wr_i && (addr_i == imac_pkg::OFF_CTRL);
        wr_cmd = wdata_i[imac_pkg::CMD_HI:imac_pkg::CMD_LO];
        rd_data = rd_i && (addr_i == imac_pkg::OFF_DATA);
        owned = master_on_bus_flag_i || slave_on_bus_flag_i;
        path_busy = sync_busy || cif.busy;
        cmd_take = wr_ctrl && (wr_cmd != imac_pkg::CMD_NONE) && owned
                   && enable_r && !path_busy;
        cmd_drop = wr_ctrl && (wr_cmd != imac_pkg::CMD_NONE)
                   && !cmd_take;
        // Smart mode: reading received data acknowledges and fetches on.
        smart_take = rd_data && smart_r && enable_r && owned && read_mode_i
                     && !path_busy;
        sync_req = cmd_take || smart_take;
        sync_in = {read_mode_i, cmd_take ? wr_cmd : imac_pkg::CMD_READ};
    end

    // Commands cross the write synchroniser; the response bit does not.
    imac_wsync #(.STAGES(SYNC_STAGES), .W(3)) u_wsync (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .req_i(sync_req),
        .data_i(sync_in),
        .req_o(cif.cmd_valid),
        .data_o(sync_out),
        .busy_o(sync_busy)
    );

    assign cif.cmd_code = sync_out[1:0];
    assign cif.cmd_read = sync_out[2];
    assign cif.ack_nack = ack_r;

    imac_seq u_seq (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .cif(cif),
        .ack_strobe_o(ack_strobe_o),
        .ack_nack_o(ack_nack_o),
        .cond_strobe_o(cond_strobe_o),
        .cond_op_o(cond_op_o)
    );

    ////////////////////////////////////////////////////////////////////////
    // Registers.

    // Control writes. Smart mode is enable-protected; the response bit is
    // writable at any time and is stored at once.
    always_comb begin
        enable_nxt = enable_r;
        ack_nxt = ack_r;
        smart_nxt = smart_r;
        mask_nxt = mask_r;
        if (wr_i && addr_i == imac_pkg::OFF_ENABLE) begin
            enable_nxt = wdata_i[imac_pkg::ENABLE_BIT];
        end
        if (wr_ctrl) begin
            ack_nxt = wdata_i[imac_pkg::ACK_BIT];
            if (!enable_r) begin
                smart_nxt = wdata_i[imac_pkg::SMART_BIT];
            end
        end
        if (wr_i && addr_i == imac_pkg::OFF_MASK) begin
            mask_nxt = wdata_i[imac_pkg::ST_W-1:0];
        end
    end

    // Sticky events: a read of status clears it, a same-cycle set wins.
    always_comb begin
        st_set = '0;
        st_set[imac_pkg::ST_DONE] = cif.done;
        st_set[imac_pkg::ST_DROP] = cmd_drop;
        st_set[imac_pkg::ST_SMART] = smart_take;
        status_nxt = status_r | st_set;
        if (rd_i && addr_i == imac_pkg::OFF_STATUS) begin
            status_nxt = st_set;
        end
    end

    // Read data, valid the cycle after the strobe; unmapped reads give 0.
    always_comb begin
        rdata_nxt = '0;
        if (rd_i) begin
            unique case (addr_i)
                imac_pkg::OFF_ENABLE: begin
                    rdata_nxt[imac_pkg::ENABLE_BIT] = enable_r;
                end
                imac_pkg::OFF_CTRL: begin
                    // The command field is a strobe and reads as zero.
                    rdata_nxt[imac_pkg::ACK_BIT] = ack_r;
                    rdata_nxt[imac_pkg::SMART_BIT] = smart_r;
                end
                imac_pkg::OFF_MASK: rdata_nxt[imac_pkg::ST_W-1:0] = mask_r;
                imac_pkg::OFF_STATUS: rdata_nxt[imac_pkg::ST_W-1:0] = status_r;
                imac_pkg::OFF_DATA: rdata_nxt[RX_W-1:0] = rx_data_i;
                imac_pkg::OFF_SYNCBUSY: rdata_nxt[0] = sync_busy;
                default: rdata_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            enable_r <= imac_pkg::CTRL_RST[imac_pkg::ENABLE_BIT];
            ack_r <= imac_pkg::CTRL_RST[imac_pkg::ACK_BIT];
            smart_r <= imac_pkg::CTRL_RST[imac_pkg::SMART_BIT];
            mask_r <= imac_pkg::STATUS_RST;
            status_r <= imac_pkg::STATUS_RST;
            rdata_r <= '0;
        end else begin
            enable_r <= enable_nxt;
            ack_r <= ack_nxt;
            smart_r <= smart_nxt;
            mask_r <= mask_nxt;
            status_r <= status_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign rdata_o = rdata_r;
    assign enable_o = enable_r;
    // Level interrupt straight from two registers, so it cannot glitch.
    assign irq_o = |(status_r & mask_r);

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    a_cmd_reads_zero: assert property (
        (rd_i && addr_i == imac_pkg::OFF_CTRL) |=> (rdata_o[17:16] == 2'h0))
        else $error("command field read back non-zero");

    a_drop_flagged: assert property (
        (wr_ctrl && wr_cmd != 2'h0 && !owned) |=> status_r[imac_pkg::ST_DROP])
        else $error("unowned command not flagged as dropped");

    a_drop_quiet: assert property (
        (wr_ctrl && !owned && !path_busy) |=> !sync_busy)
        else $error("unowned command entered the synchroniser");

    a_cmd_gated: assert property (
        sync_req |-> (master_on_bus_flag_i || slave_on_bus_flag_i))
        else $error("command taken without bus ownership");

    a_ack_immediate: assert property (
        wr_ctrl |=> (ack_r == $past(wdata_i[imac_pkg::ACK_BIT])))
        else $error("response bit not stored at once");

    a_read_seq: assert property (
        (cmd_take && read_mode_i) |-> ##SYNC_D ack_strobe_o ##1 cond_strobe_o)
        else $error("read-mode command did not ack then act");

    a_ack_value: assert property (
        ack_strobe_o |-> (ack_nack_o == $past(ack_r)))
        else $error("acknowledge value differs from response bit");

    a_write_no_ack: assert property (
        (cmd_take && !read_mode_i) |-> ##SYNC_D (!ack_strobe_o
        && cond_strobe_o == ($past(wr_cmd, SYNC_D) != 2'h2)))
        else $error("write-mode command gave a wrong bus action");

    a_smart_fires: assert property (
        smart_take |=> sync_busy ##SYNC_STAGES ack_strobe_o)
        else $error("smart read did not launch the acknowledge");

    c_read_cmd: cover property (cmd_take && read_mode_i ##SYNC_D ack_strobe_o);
    c_smart: cover property (smart_take);
    c_drop: cover property (cmd_drop && !owned);
    c_irq: cover property (irq_o);
endmodule // imac_top
`default_nettype wire

// File: bench/imac_engine_model.sv
// Behavioural I2C bus engine that sits behind the command control block.
`timescale 1ns/1ps
`default_nettype none
module imac_engine_model (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Bus state requested by the bench.
    input wire logic mb_req_i,
    input wire logic sb_req_i,
    input wire logic rd_req_i,
    // Actions from the block.
    input wire logic ack_strobe_i,
    input wire logic cond_strobe_i,
    input wire logic [1:0] cond_op_i,
    // Bus state toward the block.
    output logic master_on_bus_flag_o,
    output logic slave_on_bus_flag_o,
    output logic read_mode_o,
    output logic [7:0] rx_data_o,
    // Action counters for the bench.
    output int acks_o,
    output int conds_o
);
    // State follows the bench one cycle late, as a real engine would.
    // Each byte read shifts in a new byte, so stale data is never reused.
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            master_on_bus_flag_o <= 1'b0;
            slave_on_bus_flag_o <= 1'b0;
            read_mode_o <= 1'b0;
            rx_data_o <= 8'h5a;
            acks_o <= 0;
            conds_o <= 0;
        end else begin
            master_on_bus_flag_o <= mb_req_i;
            slave_on_bus_flag_o <= sb_req_i;
            read_mode_o <= rd_req_i;
            if (ack_strobe_i) begin
                acks_o <= acks_o + 1;
            end
            if (cond_strobe_i) begin
                conds_o <= conds_o + 1;
            end
            if (cond_strobe_i && cond_op_i == 2'h2) begin
                rx_data_o <= rx_data_o + 8'h01;
            end
        end
    end
endmodule // imac_engine_model
`default_nettype wire

// File: bench/testbench.sv
// Self-checking bench for the acknowledge and command control block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin \
    n_fail++; $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module testbench;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic mb = 1'b0, sb = 1'b0, rdm = 1'b0;
    logic [31:0] rdata_o;
    logic mbf, sbf, rmode, ack_strobe_o, ack_nack_o, cond_strobe_o;
    logic [7:0] rx;
    logic [1:0] cond_op_o;
    logic enable_o, irq_o;
    logic [31:0] d;
    int acks, conds, n_fail = 0, cmp_count = 0;
    localparam int LAT = imac_pkg::SYNC_STAGES + 1;

    // Free-running 100 MHz clock.
    always #5 clk_i = ~clk_i;

    imac_top dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .master_on_bus_flag_i(mbf), .slave_on_bus_flag_i(sbf),
        .read_mode_i(rmode), .rx_data_i(rx), .ack_strobe_o(ack_strobe_o),
        .ack_nack_o(ack_nack_o), .cond_strobe_o(cond_strobe_o),
        .cond_op_o(cond_op_o), .enable_o(enable_o), .irq_o(irq_o));

    imac_engine_model eng (.clk_i(clk_i), .rst_b_i(rst_b_i), .mb_req_i(mb),
        .sb_req_i(sb), .rd_req_i(rdm), .ack_strobe_i(ack_strobe_o),
        .cond_strobe_i(cond_strobe_o), .cond_op_i(cond_op_o),
        .master_on_bus_flag_o(mbf), .slave_on_bus_flag_o(sbf),
        .read_mode_o(rmode), .rx_data_o(rx), .acks_o(acks), .conds_o(conds));

    // One-cycle write; the strobe drops at the edge that samples it.
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= v;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    // One-cycle read; data are taken in the single cycle they stand.
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 v = rdata_o;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] ex);
        rd(a, d);
        `CHK("rdata", ex, d)
    endtask

    // Watches six cycles after the taking edge for acknowledge and condition.
    task automatic watch(input int ea, input logic nk, input int ec,
                         input logic [1:0] op);
        int ka, kc, a0, c0;
        logic n;
        logic [1:0] o;
        ka = 0;
        kc = 0;
        a0 = acks;
        c0 = conds;
        // Look mid-cycle, so cycle k shows what edge k of the path launched.
        for (int k = 1; k <= 6; k++) begin
            @(negedge clk_i);
            if (ack_strobe_o === 1'b1) begin
                ka = k;
                n = ack_nack_o;
            end
            if (cond_strobe_o === 1'b1) begin
                kc = k;
                o = cond_op_o;
            end
        end
        `CHK("ack_cycle", ea, ka)
        if (ea != 0) `CHK("ack_nack", nk, n)
        `CHK("cond_cycle", ec, kc)
        if (ec != 0) `CHK("cond_op", op, o)
        `CHK("engine_conds", (ec != 0), conds - c0)
        `CHK("engine_acks", (ea != 0), acks - a0)
    endtask

    task automatic cmd(input logic ack, input logic [1:0] c, input int ea,
                       input int ec);
        wr(imac_pkg::OFF_CTRL, {13'h0, ack, c, 16'h0});
        watch(ea, ack, ec, c);
    endtask

    task automatic t_reset();
        rd_chk(imac_pkg::OFF_CTRL, imac_pkg::CTRL_RST);
        rd_chk(8'h08, 32'h0);
        rd_chk(imac_pkg::OFF_STATUS, 32'h0);
        `CHK("irq_reset", 1'b0, irq_o)
        `CHK("enable_reset", 1'b0, enable_o)
    endtask

    // Read mode: response then condition, response written with the command.
    task automatic t_read_mode();
        wr(imac_pkg::OFF_CTRL, 32'h0000_0100);
        wr(imac_pkg::OFF_ENABLE, 32'h1);
        rd_chk(imac_pkg::OFF_ENABLE, 32'h1);
        `CHK("enable", 1'b1, enable_o)
        mb <= 1'b1;
        rdm <= 1'b1;
        cmd(1'b1, imac_pkg::CMD_STOP, LAT, LAT + 1);
        rd_chk(imac_pkg::OFF_STATUS, 32'h1);
        rd_chk(imac_pkg::OFF_CTRL, 32'h0004_0100);
        cmd(1'b0, imac_pkg::CMD_RSTART, LAT, LAT + 1);
        rd_chk(imac_pkg::OFF_CTRL, 32'h0000_0100);
        rd_chk(imac_pkg::OFF_STATUS, 32'h1);
    endtask

    // Write mode gives conditions only; a byte read command only raises done.
    task automatic t_write_mode();
        rdm <= 1'b0;
        cmd(1'b1, imac_pkg::CMD_STOP, 0, LAT);
        rd_chk(imac_pkg::OFF_STATUS, 32'h1);
        cmd(1'b0, imac_pkg::CMD_RSTART, 0, LAT);
        rd_chk(imac_pkg::OFF_STATUS, 32'h1);
        cmd(1'b0, imac_pkg::CMD_READ, 0, 0);
        rd_chk(imac_pkg::OFF_STATUS, 32'h1);
    endtask

    // A data read in smart mode fires the acknowledge action.
    task automatic t_smart();
        rdm <= 1'b1;
        repeat (2) @(posedge clk_i);
        rd_chk(imac_pkg::OFF_DATA, 32'h5a);
        watch(LAT, 1'b0, LAT + 1, imac_pkg::CMD_READ);
        rd_chk(imac_pkg::OFF_STATUS, 32'h5);
    endtask

    // Without ownership a command is dropped; either flag alone suffices.
    task automatic t_owner();
        mb <= 1'b0;
        repeat (2) @(posedge clk_i);
        cmd(1'b1, imac_pkg::CMD_RSTART, 0, 0);
        rd_chk(imac_pkg::OFF_STATUS, 32'h2);
        rd_chk(imac_pkg::OFF_CTRL, 32'h0004_0100);
        sb <= 1'b1;
        repeat (2) @(posedge clk_i);
        cmd(1'b0, imac_pkg::CMD_STOP, LAT, LAT + 1);
    endtask

    // Masked status holds the interrupt low; reading status clears it.
    task automatic t_irq();
        `CHK("irq_masked", 1'b0, irq_o)
        wr(imac_pkg::OFF_MASK, 32'h1);
        #1 `CHK("irq_set", 1'b1, irq_o)
        rd_chk(imac_pkg::OFF_STATUS, 32'h1);
        @(posedge clk_i);
        #1 `CHK("irq_clear", 1'b0, irq_o)
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Watchdog sized well above the hundred or so cycles the tests need.
    initial begin
        #100000;
        n_fail++;
        complete_run();
    end

    // Main sequence.
    initial begin
        repeat (10) @(posedge clk_i);
        rst_b_i <= 1'b1;
        t_reset();
        t_read_mode();
        t_write_mode();
        t_smart();
        t_owner();
        t_irq();
        complete_run();
    end
endmodule // testbench
`default_nettype wire
